// ---- hw/axis_sampler.sv ----
// Samples every axis position at the start of each servo cycle and keeps the previous one.
// Assumes capture is a one-cycle pulse from the bank's sequencer.
`timescale 1ns/10ps
module axis_sampler
	import pswitch_pkg::*;
(
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          ce,
	input  wire logic [NUM_AX-1:0][POS_W-1:0]  axis_pos,
	eval_if.sampler                            ev
);

	typedef struct packed {
		logic [NUM_AX-1:0][POS_W-1:0] prev;
		logic [NUM_AX-1:0][POS_W-1:0] cur;
		logic                         seen;
		logic                         valid;
	} samp_t;

	samp_t samp_reg;
	samp_t samp_next;

	always_comb begin
		samp_next = samp_reg;
		if (ev.capture) begin
			samp_next.prev  = samp_reg.cur;
			samp_next.cur   = axis_pos;
			samp_next.seen  = 1'b1;
			// A crossing needs two real samples, so the first servo cycle never fires.
			samp_next.valid = samp_reg.seen;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			samp_reg <= '0;
		end else if (ce) begin
			samp_reg <= samp_next;
		end
	end

	assign ev.prev_pos = samp_reg.prev[ev.axis_sel];
	assign ev.cur_pos  = samp_reg.cur[ev.axis_sel];
	assign ev.valid    = samp_reg.valid;

endmodule // axis_sampler

// ---- hw/eval_if.sv ----
// Carrier between the bank, its position sampler and its switch evaluator.
// Assumes all three ends run on the same clock.
`timescale 1ns/10ps
interface eval_if;
	import pswitch_pkg::*;

	logic                     capture;
	logic        [AX_W-1:0]   axis_sel;
	logic signed [POS_W-1:0]  prev_pos;
	logic signed [POS_W-1:0]  cur_pos;
	logic                     valid;
	logic signed [POS_W-1:0]  set_target;
	logic signed [POS_W-1:0]  reset_target;
	logic        [UNITS_W-1:0] units;
	logic                     set_hit;
	logic                     reset_hit;

	modport bank (output capture, axis_sel, set_target, reset_target, units,
		input prev_pos, cur_pos, valid, set_hit, reset_hit);
	modport sampler (input capture, axis_sel, output prev_pos, cur_pos, valid);
	modport evaluator (input prev_pos, cur_pos, valid, set_target, reset_target, units,
		output set_hit, reset_hit);

endinterface

// ---- hw/position_switch_bank.sv ----
// Bank of position-compare switches driving digital outputs, configured over APB.
// Assumes servo_tick is a one-cycle pulse at least NUM_SW + 2 cycles apart and
// that axis_pos is synchronous to pclk.
`timescale 1ns/10ps
// Functional notes
// RQ1: Enabled switch drives its output active when its axis reaches the set position.
// RQ2: Enabled switch drives its output inactive when its axis reaches the reset position.
// RQ3: Sixteen independent switches, each assignable to any axis.
// RQ4: Every switch keeps its own set, reset position and output number.
// RQ5: Software picks a switch with index 0 to 15.
// RQ6: Full configuration has seven parameters; two-parameter form with enable clear disables.
// RQ7: All enabled switches are evaluated once per servo cycle, then outputs updated.
// RQ8: Output responds about one servo-cycle period after the position is reached.
// RQ9: Disabling keeps the output; software clears it with the output write command.
// RQ10: Each switch has a configured on or off state driven at the set position.
// RQ11: Positions are absolute user units scaled by the axis unit factor.
module position_switch_bank
	import pswitch_pkg::*;
(
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          ce,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [ADDR_W-1:0]             paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          servo_tick,
	input  wire logic [NUM_AX-1:0][POS_W-1:0]  axis_pos,
	output logic      [NUM_OUT-1:0]            dout
);

	typedef struct packed {
		seq_state_t                           state;
		logic [IDX_W-1:0]                     idx;
		logic [IDX_W-1:0]                     st_index;
		logic [AX_W-1:0]                      st_axis;
		logic [OUT_W-1:0]                     st_out;
		logic                                 st_state;
		logic [POS_W-1:0]                     st_set;
		logic [POS_W-1:0]                     st_reset;
		logic [NUM_SW-1:0]                    en;
		logic [NUM_SW-1:0][AX_W-1:0]          cfg_axis;
		logic [NUM_SW-1:0][OUT_W-1:0]         cfg_out;
		logic [NUM_SW-1:0]                    cfg_state;
		logic [NUM_SW-1:0][POS_W-1:0]         cfg_set;
		logic [NUM_SW-1:0][POS_W-1:0]         cfg_reset;
		logic [NUM_AX-1:0][UNITS_W-1:0]       units;
		logic [NUM_OUT-1:0]                   out_img;
		logic [NUM_OUT-1:0]                   out_pend;
		logic                                 bad_cmd;
		logic [31:0]                          rdata;
		logic                                 err;
	} bank_t;

	bank_t bank_reg;
	bank_t bank_next;

	eval_if ev ();

	axis_sampler u_sampler (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.axis_pos (axis_pos),
		.ev       (ev.sampler)
	);

	switch_eval u_eval (
		.ev (ev.evaluator)
	);

	function automatic reg_id_t reg_decode(input logic [ADDR_W-1:0] a);
		if (a[1:0] != 2'b00) begin
			reg_decode = R_NONE;
		end else if ((a >= OFF_UNITS_BASE) && (a < OFF_ENABLES)) begin
			reg_decode = R_UNITS;
		end else begin
			case (a)
				OFF_SW_INDEX:   reg_decode = R_INDEX;
				OFF_SW_AXIS:    reg_decode = R_AXIS;
				OFF_SW_OUTNUM:  reg_decode = R_OUTNUM;
				OFF_SW_OUTST:   reg_decode = R_OUTST;
				OFF_SW_SETPOS:  reg_decode = R_SETPOS;
				OFF_SW_RSTPOS:  reg_decode = R_RSTPOS;
				OFF_SW_COMMAND: reg_decode = R_COMMAND;
				OFF_OUT_WRITE:  reg_decode = R_OUTWR;
				OFF_ENABLES:    reg_decode = R_ENABLES;
				OFF_STATUS:     reg_decode = R_STATUS;
				default:        reg_decode = R_NONE;
			endcase
		end
	endfunction

	logic             setup;
	logic             wr_acc;
	reg_id_t          rid;
	logic [AX_W-1:0]  unit_ax;
	logic [IDX_W-1:0] cur;

	assign setup   = psel && !penable;
	assign wr_acc  = psel && penable && pwrite;
	assign rid     = reg_decode(paddr);
	assign unit_ax = paddr[AX_W+1:2];
	assign cur     = bank_reg.idx;

	assign ev.capture      = (bank_reg.state == ST_IDLE) && servo_tick;
	assign ev.axis_sel     = bank_reg.cfg_axis[cur]; // RQ3
	assign ev.set_target   = bank_reg.cfg_set[cur];
	assign ev.reset_target = bank_reg.cfg_reset[cur];
	assign ev.units        = bank_reg.units[bank_reg.cfg_axis[cur]];

	always_comb begin
		bank_next = bank_reg;

		case (bank_reg.state)
			ST_IDLE: begin
				if (servo_tick) begin
					bank_next.state    = ST_EVAL;
					bank_next.idx      = '0;
					bank_next.out_pend = bank_reg.out_img;
				end
			end
			ST_EVAL: begin
				// A later switch on the same output overrides an earlier one; reset beats set.
				if (bank_reg.en[cur]) begin // RQ7
					if (ev.set_hit) begin
						bank_next.out_pend[bank_reg.cfg_out[cur]] = bank_reg.cfg_state[cur]; // RQ10
					end
					if (ev.reset_hit) begin
						bank_next.out_pend[bank_reg.cfg_out[cur]] = !bank_reg.cfg_state[cur]; // RQ2
					end
				end
				bank_next.idx = bank_reg.idx + 4'h1;
				if (bank_reg.idx == IDX_W'(NUM_SW - 1)) begin
					bank_next.state = ST_APPLY;
				end
			end
			ST_APPLY: begin
				// All outputs change together so the pins never show a half-scanned cycle.
				bank_next.out_img = bank_reg.out_pend; // RQ8
				bank_next.state   = ST_IDLE;
			end
			default: begin
				bank_next.state = ST_IDLE;
			end
		endcase

		if (wr_acc) begin
			case (rid)
				R_INDEX:  bank_next.st_index = pwdata[IDX_W-1:0]; // RQ5
				R_AXIS:   bank_next.st_axis  = pwdata[AX_W-1:0];
				R_OUTNUM: bank_next.st_out   = pwdata[OUT_W-1:0];
				R_OUTST:  bank_next.st_state = pwdata[0];
				R_SETPOS: bank_next.st_set   = pwdata;
				R_RSTPOS: bank_next.st_reset = pwdata;
				R_UNITS: begin
					// A zero factor would collapse every target onto zero, so it is refused.
					if (pwdata[UNITS_W-1:0] != '0) begin
						bank_next.units[unit_ax] = pwdata[UNITS_W-1:0]; // RQ11
					end
				end
				R_COMMAND: begin
					bank_next.bad_cmd = 1'b0;
					if (pwdata[CMD_FULL_BIT]) begin // RQ6
						bank_next.en[bank_reg.st_index]        = pwdata[CMD_ENABLE_BIT];
						bank_next.cfg_axis[bank_reg.st_index]  = bank_reg.st_axis; // RQ4
						bank_next.cfg_out[bank_reg.st_index]   = bank_reg.st_out;
						bank_next.cfg_state[bank_reg.st_index] = bank_reg.st_state;
						bank_next.cfg_set[bank_reg.st_index]   = bank_reg.st_set;
						bank_next.cfg_reset[bank_reg.st_index] = bank_reg.st_reset;
					end else if (!pwdata[CMD_ENABLE_BIT]) begin
						// Only the enable drops; the output keeps whatever it had.
						bank_next.en[bank_reg.st_index] = 1'b0; // RQ9
					end else begin
						bank_next.bad_cmd = 1'b1; // RQ6
					end
				end
				R_OUTWR: begin
					// Written into both images so a scan in progress cannot undo it.
					bank_next.out_img[pwdata[OUT_W-1:0]]  = pwdata[OPW_VALUE_BIT]; // RQ9
					bank_next.out_pend[pwdata[OUT_W-1:0]] = pwdata[OPW_VALUE_BIT];
				end
				default: begin
				end
			endcase
		end

		if (setup) begin
			bank_next.err   = (rid == R_NONE);
			bank_next.rdata = '0;
			case (rid)
				R_INDEX:   bank_next.rdata[IDX_W-1:0] = bank_reg.st_index;
				R_AXIS:    bank_next.rdata[AX_W-1:0]  = bank_reg.st_axis;
				R_OUTNUM:  bank_next.rdata[OUT_W-1:0] = bank_reg.st_out;
				R_OUTST:   bank_next.rdata[0]         = bank_reg.st_state;
				R_SETPOS:  bank_next.rdata            = bank_reg.st_set;
				R_RSTPOS:  bank_next.rdata            = bank_reg.st_reset;
				R_COMMAND: bank_next.rdata[CMD_ENABLE_BIT] = bank_reg.en[bank_reg.st_index];
				R_OUTWR:   bank_next.rdata[NUM_OUT-1:0] = bank_reg.out_img;
				R_UNITS:   bank_next.rdata[UNITS_W-1:0] = bank_reg.units[unit_ax];
				R_ENABLES: bank_next.rdata[NUM_SW-1:0]  = bank_reg.en;
				R_STATUS: begin
					bank_next.rdata[STAT_BUSY_BIT] = (bank_reg.state != ST_IDLE);
					bank_next.rdata[STAT_BAD_BIT]  = bank_reg.bad_cmd;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bank_reg       <= '0;
			bank_reg.units <= {NUM_AX{UNITS_RST}};
		end else if (ce) begin
			bank_reg <= bank_next;
		end
	end

	assign pready  = 1'b1;
	assign prdata  = bank_reg.rdata;
	assign pslverr = bank_reg.err;
	assign dout    = bank_reg.out_img; // RQ7

endmodule // position_switch_bank

// ---- hw/pswitch_pkg.sv ----
// Package for the position switch bank: sizes, register offsets, reset values and states.
// Assumes a 32-bit APB with byte addresses; every register takes one aligned word.
package pswitch_pkg;

	localparam int NUM_SW  = 16;
	localparam int NUM_AX  = 4;
	localparam int NUM_OUT = 16;
	localparam int POS_W   = 32;
	localparam int UNITS_W = 16;
	localparam int IDX_W   = 4;
	localparam int AX_W    = 2;
	localparam int OUT_W   = 4;
	localparam int ADDR_W  = 8;
	localparam int PROD_W  = POS_W + UNITS_W + 1;

	localparam logic [ADDR_W-1:0] OFF_SW_INDEX   = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_SW_AXIS    = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_SW_OUTNUM  = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_SW_OUTST   = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_SW_SETPOS  = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_SW_RSTPOS  = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_SW_COMMAND = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_OUT_WRITE  = 8'h1C;
	localparam logic [ADDR_W-1:0] OFF_UNITS_BASE = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_ENABLES    = 8'h30;
	localparam logic [ADDR_W-1:0] OFF_STATUS     = 8'h34;

	// Field positions.
	localparam int CMD_ENABLE_BIT = 0;
	localparam int CMD_FULL_BIT   = 1;
	localparam int OPW_VALUE_BIT  = 8;
	localparam int STAT_BUSY_BIT  = 0;
	localparam int STAT_BAD_BIT   = 1;

	localparam logic [UNITS_W-1:0] UNITS_RST = 16'h0001;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_EVAL  = 2'b01,
		ST_APPLY = 2'b10
	} seq_state_t;

	typedef enum logic [3:0] {
		R_INDEX   = 4'h0,
		R_AXIS    = 4'h1,
		R_OUTNUM  = 4'h2,
		R_OUTST   = 4'h3,
		R_SETPOS  = 4'h4,
		R_RSTPOS  = 4'h5,
		R_COMMAND = 4'h6,
		R_OUTWR   = 4'h7,
		R_UNITS   = 4'h8,
		R_ENABLES = 4'h9,
		R_STATUS  = 4'hA,
		R_NONE    = 4'hF
	} reg_id_t;

endpackage

// ---- hw/switch_eval.sv ----
// Decides whether the selected axis crossed a switch's set or reset position this servo cycle.
// Assumes positions are raw measured counts and targets are user units times the axis factor.
`timescale 1ns/10ps
module switch_eval
	import pswitch_pkg::*;
(
	eval_if.evaluator ev
);

	logic signed [PROD_W-1:0] set_raw;
	logic signed [PROD_W-1:0] reset_raw;
	logic signed [PROD_W-1:0] prev_x;
	logic signed [PROD_W-1:0] cur_x;

	// Reached means the target lies in the travel from the last sample to this one, either way.
	function automatic logic crossed(input logic signed [PROD_W-1:0] p,
		input logic signed [PROD_W-1:0] c, input logic signed [PROD_W-1:0] t);
		crossed = ((p < t) && (t <= c)) || ((c <= t) && (t < p));
	endfunction

	// Scaling the target rather than dividing the position keeps this exact and divider-free.
	assign set_raw   = PROD_W'(ev.set_target * $signed({1'b0, ev.units})); // RQ11
	assign reset_raw = PROD_W'(ev.reset_target * $signed({1'b0, ev.units})); // RQ11
	assign prev_x    = PROD_W'(ev.prev_pos);
	assign cur_x     = PROD_W'(ev.cur_pos);

	assign ev.set_hit   = ev.valid && crossed(prev_x, cur_x, set_raw); // RQ1
	assign ev.reset_hit = ev.valid && crossed(prev_x, cur_x, reset_raw); // RQ2

endmodule // switch_eval

// ---- tb/axis_model.sv ----
// Axis measurement model: a servo tick every GAP cycles and encoder snapshots.
// Assumes the bench supplies the demanded positions and the clock.
`timescale 1ns/10ps
module axis_model
	import pswitch_pkg::*;
#(
	parameter int GAP = 20
)(
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic [NUM_AX-1:0][POS_W-1:0] demand,
	output logic                              servo_tick,
	output logic      [NUM_AX-1:0][POS_W-1:0] axis_pos
);
	int cnt;
	// Positions move once per servo cycle, so no capture sees a half-updated set.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			servo_tick <= 1'h0;
			axis_pos <= '0;
		end else begin
			cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
			servo_tick <= (cnt == GAP - 1);
			if (cnt == 0)
				axis_pos <= demand;
		end
	end
endmodule // axis_model

// ---- tb/position_switch_bank_monitor.sv ----
// Checker for the switch bank, watching only its top-level ports.
// Assumes ce is high while transfers that are checked take place.
`timescale 1ns/10ps
module position_switch_bank_monitor
	import pswitch_pkg::*;
(
	input wire logic                     pclk,
	input wire logic                     presetn,
	input wire logic                     ce,
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic                     pwrite,
	input wire logic      [ADDR_W-1:0]   paddr,
	input wire logic      [31:0]         pwdata,
	input wire logic      [31:0]         prdata,
	input wire logic                     pready,
	input wire logic                     pslverr,
	input wire logic                     servo_tick,
	input wire logic      [NUM_OUT-1:0]  dout
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc, bad, ow;
	assign acc = psel && penable && ce;
	assign bad = (paddr[1:0] != 2'h0) || (paddr > OFF_STATUS);
	assign ow = acc && pwrite && (paddr == OFF_OUT_WRITE);
	no_wait_a: assert property (pready) else $error("pready low");
	err_unmapped_a: assert property (acc && $past(ce) && bad |-> pslverr)
		else $error("no error on unmapped access");
	err_mapped_a: assert property (acc && $past(ce) && !bad |-> !pslverr)
		else $error("error on mapped access");
	rd_unmapped_a: assert property (acc && !pwrite && $past(ce) && bad |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	out_update_a: assert property ($changed(dout) |-> $past(ow) || $past(servo_tick, 17) ||
		$past(servo_tick, 18) || $past(servo_tick, 19)) else $error("dout changed off cycle");
	out_write_a: assert property (ow |=> dout[$past(pwdata[3:0])] == $past(pwdata[8]))
		else $error("output write not applied");
	out_read_a: assert property (acc && !pwrite && $past(ce) && paddr == OFF_OUT_WRITE
		|-> prdata == {16'h0000, $past(dout)}) else $error("output readback wrong");
	en_read_a: assert property (acc && !pwrite && paddr == OFF_ENABLES |->
		prdata[31:16] == 16'h0000) else $error("enable upper bits set");
	cmd_read_a: assert property (acc && !pwrite && paddr == OFF_SW_COMMAND |->
		prdata[31:1] == 31'h0) else $error("command upper bits set");
endmodule // position_switch_bank_monitor
bind position_switch_bank position_switch_bank_monitor mon_u (.pclk, .presetn, .ce, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .servo_tick, .dout);

// ---- tb/position_switch_bank_tb.sv ----
// Self-checking bench for the switch bank: APB master plus the axis model.
// Assumes ce is high except where a scenario drops it; dout is judged several servo cycles after each move.
`timescale 1ns/10ps
module position_switch_bank_tb
	import pswitch_pkg::*;
;
	logic                         pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic                         servo_tick, ce;
	logic [ADDR_W-1:0]            paddr;
	logic [31:0]                  pwdata, prdata, rd;
	logic [NUM_AX-1:0][POS_W-1:0] axis_pos, demand;
	logic [NUM_OUT-1:0]           dout;
	int                           error_cnt, compares;

	position_switch_bank dut_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .servo_tick, .axis_pos, .dout);
	axis_model model_u (.pclk, .presetn, .demand, .servo_tick, .axis_pos);

	always #2.5 pclk = ~pclk;

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task automatic rdchk(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e);
		xfer(1'h0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	task automatic cfg(input logic [31:0] sw, ax, o, st, sp, rp);
		logic [31:0] v [6];
		v = '{sw, ax, o, st, sp, rp};
		for (int i = 0; i < 6; i++)
			xfer(1'h1, ADDR_W'(4 * i), v[i]);
		xfer(1'h1, OFF_SW_COMMAND, 32'h3);
	endtask
	task automatic move(input int ax, input logic [31:0] p, input logic [15:0] e);
		demand[ax] <= p;
		repeat (100) @(posedge pclk);
		chk("dout", {16'h0000, e}, {16'h0000, dout});
	endtask

	task automatic t_regs();
		rdchk("units", OFF_UNITS_BASE, 32'h1);
		xfer(1'h1, 8'h24, 32'h0);
		rdchk("units zero", 8'h24, 32'h1);
		xfer(1'h1, OFF_ENABLES, 32'hFFFF);
		rdchk("enables", OFF_ENABLES, 32'h0);
		rdchk("unmapped", 8'h38, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, err});
		xfer(1'h0, 8'h02, 32'h0);
		chk("unaligned err", 32'h1, {31'h0, err});
	endtask
	task automatic t_cross();
		logic [31:0] p1 [4] = '{199, 200, 399, 400};
		logic [31:0] p2 [4] = '{49, 50, 149, 150};
		logic [15:0] e [4] = '{16'h0200, 16'h0020, 16'h0020, 16'h0200};
		xfer(1'h1, 8'h24, 32'h2);
		cfg(3, 1, 5, 1, 100, 200);
		cfg(15, 2, 9, 0, 50, 150);
		xfer(1'h1, OFF_OUT_WRITE, 32'h109);
		rdchk("enables", OFF_ENABLES, 32'h8008);
		rdchk("cmd en", OFF_SW_COMMAND, 32'h1);
		rdchk("setpos", OFF_SW_SETPOS, 32'h32);
		for (int i = 0; i < 4; i++) begin
			demand[1] <= p1[i];
			move(2, p2[i], e[i]);
		end
		rdchk("out read", OFF_OUT_WRITE, 32'h0200);
	endtask
	task automatic t_dis();
		move(1, 200, 16'h0220);
		xfer(1'h1, OFF_SW_INDEX, 32'h3);
		xfer(1'h1, OFF_SW_COMMAND, 32'h0);
		rdchk("enables", OFF_ENABLES, 32'h8000);
		rdchk("cmd en", OFF_SW_COMMAND, 32'h0);
		move(1, 500, 16'h0220);
		xfer(1'h1, OFF_OUT_WRITE, 32'h5);
		chk("cleared", 32'h0200, {16'h0000, dout});
		xfer(1'h1, OFF_SW_COMMAND, 32'h1);
		// The scan keeps the bank busy most of each servo cycle, so the read is placed on a tick.
		do @(posedge pclk); while (servo_tick !== 1'h1);
		rdchk("status", OFF_STATUS, 32'h3);
		rdchk("enables", OFF_ENABLES, 32'h8000);
	endtask

	task automatic t_freeze();
		ce <= 1'h0;
		xfer(1'h1, OFF_OUT_WRITE, 32'h9);
		chk("frozen", 32'h0200, {16'h0000, dout});
		ce <= 1'h1;
		@(posedge pclk);
	endtask
	task automatic t_rst();
		presetn <= 1'h0;
		@(posedge pclk);
		chk("reset dout", 32'h0, {16'h0000, dout});
		presetn <= 1'h1;
		@(posedge pclk);
		rdchk("units reset", 8'h24, 32'h1);
		rdchk("enables reset", OFF_ENABLES, 32'h0);
	endtask

	task automatic give_verdict();
		$display("Comparisons %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		pclk = 1'h0;
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = '0;
		pwdata = '0;
		demand = '0;
		ce = 1'h1;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_regs();
		t_cross();
		t_dis();
		t_freeze();
		t_rst();
		give_verdict();
	end
	initial begin
		repeat (5000) @(posedge pclk);
		error_cnt++;
		give_verdict();
	end
endmodule // position_switch_bank_tb
